// [supply_status_pkg.sv]
// register map, field positions and reset values of the supply status flag bank
package supply_status_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_HEALTH        = 8'h01;
   localparam logic [7:0] ADDR_FAULT_PIN     = 8'h02;
   localparam logic [7:0] ADDR_MON_LATCH     = 8'h2A;
   localparam logic [7:0] ADDR_HEALTH_LATCH  = 8'h2B;
   localparam logic [7:0] ADDR_FAULT_LATCH   = 8'h2C;
   localparam logic [7:0] READ_UNMAPPED      = 8'h00;
   // ------------------------------------------------------------
   // power_health_status fields
   // ------------------------------------------------------------
   localparam int H_OV_FLAG  = 0;
   localparam int H_EXT_REF  = 1;
   localparam int H_INT_REF  = 2;
   localparam int H_GROUND   = 3;
   localparam int H_SUPPLY   = 4;
   localparam int H_REVERSE  = 5;
   localparam int H_ORING    = 6;
   localparam int H_SHARE    = 7;
   // ------------------------------------------------------------
   // fault_and_pin_status fields
   // ------------------------------------------------------------
   localparam int F_FAULT    = 0;
   localparam int F_PULSE    = 1;
   localparam int F_OCP      = 2;
   localparam int F_DC_GOOD  = 3;
   localparam int F_PON_LINK = 4;
   localparam int F_ENABLE   = 5;
   localparam int F_PON      = 6;
   localparam int F_LINE     = 7;
   // ------------------------------------------------------------
   // monitor_fault_latches fields (bits 0..4 hold inputs 5..1)
   // ------------------------------------------------------------
   localparam int M_MON_BASE = 0;
   localparam int M_OCP_TO   = 5;
   localparam int M_UV       = 6;
   localparam int M_OV       = 7;
   // ------------------------------------------------------------
   // reset values: every flag in its healthy state
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_HEALTH    = 8'hFE;
   localparam logic [7:0] RESET_FAULT_PIN = 8'hFA;
   localparam logic [7:0] RESET_MONITOR   = 8'h00;
   // a set bit marks a flag whose fault state is high
   localparam logic [7:0] HIGH_HEALTH     = 8'h01;
   localparam logic [7:0] HIGH_FAULT_PIN  = 8'h05;
   localparam logic [7:0] HIGH_MONITOR    = 8'hFF;
endpackage

// [status_flag_if.sv]
// bundle of raw detector levels and registered live flag bytes
`timescale 1ns/1ps
interface status_flag_if;
   logic       supply_ov;
   logic       ext_ref_overload;
   logic       int_ref_lost;
   logic       ground_open;
   logic       supply_uvlo;
   logic       reverse_excess;
   logic       enable_good;
   logic       load_good;
   logic       share_out;
   logic       ov_fault;
   logic       uv_fault;
   logic       ocp_event;
   logic       pulse_seen;
   logic       oc_sensed;
   logic       ocp_running;
   logic       ocp_timeout;
   logic [4:0] pins;
   logic [4:0] mon;
   logic [7:0] health;
   logic [7:0] fault_pin;
   logic [7:0] monitor;
   modport sampler (input  supply_ov, ext_ref_overload, int_ref_lost, ground_open, supply_uvlo,
                    input  reverse_excess, enable_good, load_good, share_out, ov_fault,
                    input  uv_fault, ocp_event, pulse_seen, oc_sensed, ocp_running,
                    input  ocp_timeout, pins, mon,
                    output health, fault_pin, monitor);
   modport bank    (input health, fault_pin, monitor);
endinterface

// [flag_sampler.sv]
// registers the live status bytes from raw detector levels
`timescale 1ns/1ps
module flag_sampler (
   input wire logic     ref_clk,
   input wire logic     rstn,
   input wire logic     ce,
   status_flag_if.sampler f
);
   logic supply_good;
   logic pulse_good;
   logic oring_good;
   logic fault_seen;

   assign pulse_good  = f.pulse_seen;
   // any reference, ground or overvoltage problem also drops supply health
   assign supply_good = ~(f.supply_uvlo | f.ext_ref_overload | f.int_ref_lost
                          | f.ground_open | f.supply_ov);
   assign oring_good  = pulse_good & f.enable_good & f.load_good & ~f.reverse_excess;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         f.health <= supply_status_pkg::RESET_HEALTH;
      end else if (ce) begin
         f.health <= {~f.share_out, oring_good, ~f.reverse_excess, supply_good,
                      ~f.ground_open, ~f.int_ref_lost, ~f.ext_ref_overload, f.supply_ov};
      end
   end

   // fault latch stays set until reset; nothing in the block clears it
   assign fault_seen = f.fault_pin[supply_status_pkg::F_FAULT]
                       | f.ov_fault | f.uv_fault | f.ocp_event;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         f.fault_pin <= supply_status_pkg::RESET_FAULT_PIN;
         f.monitor   <= supply_status_pkg::RESET_MONITOR;
      end else if (ce) begin
         f.fault_pin <= {f.pins, f.oc_sensed & f.ocp_running, pulse_good, fault_seen};
         f.monitor   <= {f.ov_fault, f.uv_fault, f.ocp_timeout, f.mon};
      end
   end
endmodule

// [sticky_latch_bank.sv]
// eight sticky bits that each keep the fault state of one live flag
`timescale 1ns/1ps
module sticky_latch_bank #(
   parameter logic [7:0] FAULT_HIGH  = 8'h00,
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   input  wire logic [7:0] live,
   output logic      [7:0] latched
);
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         // one flop per bit keeps each process the only writer of its variable
         logic held;
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               held <= RESET_VALUE[i];
            end else if (ce) begin
               // high-fault flags stick high, good flags stick low
               held <= FAULT_HIGH[i] ? (held | live[i]) : (held & live[i]);
            end
         end
         assign latched[i] = held;
      end
   endgenerate
endmodule

// [supply_status_flag_bank.sv]
// top of the supply status flag bank: live flags, latches and register reads
`timescale 1ns/1ps

// How it works
// - supply overvoltage sets health bit 0
// - external reference overload clears bit 1
// - internal reference loss clears bit 2
// - open ground clears bit 3
// - uvlo, reference, ground or overvoltage clear bit 4
// - excess oring reverse voltage clears bit 5
// - oring good needs pulse, enable, load, reverse
// - share accuracy out of limits clears bit 7
// - fault latch set by ov, uv, ocp
// - line pulses set pulse present bit
// - overcurrent with running timer sets pending bit
// - bits 3 to 7 mirror five pins
// - monitor latch register holds mon, timeout, uv, ov
// - two latch registers keep each live register bit stuck in its fault state until reset
module supply_status_flag_bank (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   input  wire logic       supply_overvoltage_flag,
   input  wire logic       ext_ref_overload,
   input  wire logic       int_ref_lost,
   input  wire logic       ground_open,
   input  wire logic       supply_uvlo,
   input  wire logic       reverse_voltage_excess,
   input  wire logic       enable_good,
   input  wire logic       load_voltage_good,
   input  wire logic       share_out_of_limit,
   input  wire logic       ov_fault,
   input  wire logic       uv_fault,
   input  wire logic       ocp_event,
   input  wire logic       line_pulse_detect,
   input  wire logic       overcurrent_sensed,
   input  wire logic       ocp_timer_running,
   input  wire logic       ocp_timeout,
   input  wire logic       dc_good_pin_state,
   input  wire logic       power_on_link_pin,
   input  wire logic       enable_pin,
   input  wire logic       power_on_pin,
   input  wire logic       line_sense_pin,
   input  wire logic [4:0] monitor_input,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   output logic      [7:0] reg_rdata,
   output logic            reg_rd_valid,
   output logic            reg_wr_done,
   output logic            reg_addr_error
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic addr_mapped(input logic [7:0] a);
      return a == supply_status_pkg::ADDR_HEALTH
          || a == supply_status_pkg::ADDR_FAULT_PIN
          || a == supply_status_pkg::ADDR_MON_LATCH
          || a == supply_status_pkg::ADDR_HEALTH_LATCH
          || a == supply_status_pkg::ADDR_FAULT_LATCH;
   endfunction

   status_flag_if flags ();

   logic [7:0] health_latch;
   logic [7:0] fault_latch;
   logic [7:0] monitor_latch;
   logic [7:0] next_rdata;

   // ------------------------------------------------------------
   // raw levels into the sampler
   // ------------------------------------------------------------
   assign flags.supply_ov        = supply_overvoltage_flag;
   assign flags.ext_ref_overload = ext_ref_overload;
   assign flags.int_ref_lost     = int_ref_lost;
   assign flags.ground_open      = ground_open;
   assign flags.supply_uvlo      = supply_uvlo;
   assign flags.reverse_excess   = reverse_voltage_excess;
   assign flags.enable_good      = enable_good;
   assign flags.load_good        = load_voltage_good;
   assign flags.share_out        = share_out_of_limit;
   assign flags.ov_fault         = ov_fault;
   assign flags.uv_fault         = uv_fault;
   assign flags.ocp_event        = ocp_event;
   assign flags.pulse_seen       = line_pulse_detect;
   assign flags.oc_sensed        = overcurrent_sensed;
   assign flags.ocp_running      = ocp_timer_running;
   assign flags.ocp_timeout      = ocp_timeout;
   // pin order fixes bits 3 (dc good) up to 7 (line sense)
   assign flags.pins = {line_sense_pin, power_on_pin, enable_pin,
                        power_on_link_pin, dc_good_pin_state};
   // inputs 5..1 land on bits 0..4, so the vector is reversed
   assign flags.mon  = {monitor_input[0], monitor_input[1], monitor_input[2],
                        monitor_input[3], monitor_input[4]};

   flag_sampler u_sampler (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .f       (flags.sampler)
   );

   // ------------------------------------------------------------
   // sticky latches
   // ------------------------------------------------------------
   sticky_latch_bank #(
      .FAULT_HIGH  (supply_status_pkg::HIGH_HEALTH),
      .RESET_VALUE (supply_status_pkg::RESET_HEALTH)
   ) u_health_latch (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .live    (flags.health),
      .latched (health_latch)
   );

   sticky_latch_bank #(
      .FAULT_HIGH  (supply_status_pkg::HIGH_FAULT_PIN),
      .RESET_VALUE (supply_status_pkg::RESET_FAULT_PIN)
   ) u_fault_latch (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .live    (flags.fault_pin),
      .latched (fault_latch)
   );

   sticky_latch_bank #(
      .FAULT_HIGH  (supply_status_pkg::HIGH_MONITOR),
      .RESET_VALUE (supply_status_pkg::RESET_MONITOR)
   ) u_monitor_latch (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .live    (flags.monitor),
      .latched (monitor_latch)
   );

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         supply_status_pkg::ADDR_HEALTH:       next_rdata = flags.health;
         supply_status_pkg::ADDR_FAULT_PIN:    next_rdata = flags.fault_pin;
         supply_status_pkg::ADDR_MON_LATCH:    next_rdata = monitor_latch;
         supply_status_pkg::ADDR_HEALTH_LATCH: next_rdata = health_latch;
         supply_status_pkg::ADDR_FAULT_LATCH:  next_rdata = fault_latch;
         default:                              next_rdata = supply_status_pkg::READ_UNMAPPED;
      endcase
   end

   // read data holds until the next read so the host may sample late
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= supply_status_pkg::READ_UNMAPPED;
      end else if (ce && reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rd_valid   <= 1'b0;
         reg_wr_done    <= 1'b0;
         reg_addr_error <= 1'b0;
      end else if (ce) begin
         reg_rd_valid   <= reg_rd;
         // a write is acknowledged but touches no state
         reg_wr_done    <= reg_wr;
         reg_addr_error <= (reg_rd | reg_wr) & ~addr_mapped(reg_addr);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   logic       seen_reset;
   logic [7:0] health_before;
   logic [7:0] fault_before;
   logic [7:0] monitor_before;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seen_reset <= 1'b0;
      end else begin
         seen_reset <= 1'b1;
      end
   end

   // snapshot of every latch for the latch hold checks
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         health_before  <= supply_status_pkg::RESET_HEALTH;
         fault_before   <= supply_status_pkg::RESET_FAULT_PIN;
         monitor_before <= supply_status_pkg::RESET_MONITOR;
      end else begin
         health_before  <= health_latch;
         fault_before   <= fault_latch;
         monitor_before <= monitor_latch;
      end
   end

   sequence s_sampled;
      ce ##1 1'b1;
   endsequence

   sequence s_fault_event;
      ce && (ov_fault || uv_fault || ocp_event);
   endsequence

   chk_supply_ov_bit: assert property (s_sampled |->
      flags.health[supply_status_pkg::H_OV_FLAG] == $past(supply_overvoltage_flag))
      else $error("overvoltage bit does not follow detector");

   chk_ext_ref_bit: assert property (s_sampled |->
      flags.health[supply_status_pkg::H_EXT_REF] == !$past(ext_ref_overload))
      else $error("external reference bit wrong");

   chk_int_ref_bit: assert property (s_sampled |->
      flags.health[supply_status_pkg::H_INT_REF] == !$past(int_ref_lost))
      else $error("internal reference bit wrong");

   chk_ground_bit: assert property (ce && ground_open |=>
      !flags.health[supply_status_pkg::H_GROUND])
      else $error("open ground not reported");

   chk_supply_good: assert property (ce && (supply_uvlo || int_ref_lost || ext_ref_overload
      || ground_open || supply_overvoltage_flag) |=> !flags.health[supply_status_pkg::H_SUPPLY])
      else $error("supply good stayed high on a cause");

   chk_supply_ok_up: assert property (ce && !(supply_uvlo || int_ref_lost || ext_ref_overload
      || ground_open || supply_overvoltage_flag) |=> flags.health[supply_status_pkg::H_SUPPLY])
      else $error("supply good low with no cause");

   chk_reverse_bit: assert property (s_sampled |->
      flags.health[supply_status_pkg::H_REVERSE] == !$past(reverse_voltage_excess))
      else $error("reverse voltage bit wrong");

   chk_oring_good: assert property (s_sampled |-> flags.health[supply_status_pkg::H_ORING] ==
      $past(line_pulse_detect && enable_good && load_voltage_good && !reverse_voltage_excess))
      else $error("oring good mismatch");

   chk_share_bit: assert property (ce && share_out_of_limit |=>
      !flags.health[supply_status_pkg::H_SHARE])
      else $error("share accuracy not reported");

   chk_fault_sticky: assert property (s_fault_event |=>
      flags.fault_pin[supply_status_pkg::F_FAULT] [*4])
      else $error("fault latch did not set and hold");

   chk_pulse_bit: assert property (s_sampled |->
      flags.fault_pin[supply_status_pkg::F_PULSE] == $past(line_pulse_detect))
      else $error("pulse present bit wrong");

   chk_ocp_pending: assert property (s_sampled |-> flags.fault_pin[supply_status_pkg::F_OCP]
      == $past(overcurrent_sensed && ocp_timer_running))
      else $error("overcurrent pending bit wrong");

   chk_pin_mirror: assert property (s_sampled |-> flags.fault_pin[7:3] ==
      $past({line_sense_pin, power_on_pin, enable_pin, power_on_link_pin, dc_good_pin_state}))
      else $error("pin mirror bits wrong");

   chk_mon_latch: assert property (ce && monitor_input[4] ##1 ce |=>
      monitor_latch[supply_status_pkg::M_MON_BASE])
      else $error("input five latch not set");

   chk_ov_latch: assert property (ce && ov_fault ##1 ce |=>
      monitor_latch[supply_status_pkg::M_OV] [*3])
      else $error("overvoltage fault latch not held");

   chk_health_copy: assert property (ce && !flags.health[supply_status_pkg::H_SHARE] |=>
      !health_latch[supply_status_pkg::H_SHARE])
      else $error("share latch missed the live fault");

   chk_fault_copy: assert property (ce && flags.fault_pin[supply_status_pkg::F_OCP] |=>
      fault_latch[supply_status_pkg::F_OCP])
      else $error("overcurrent latch missed the live flag");

   chk_latch_hold: assert property (seen_reset |->
      ((health_latch | supply_status_pkg::HIGH_HEALTH) == (health_before | supply_status_pkg::HIGH_HEALTH)
       || (health_latch & ~health_before & ~supply_status_pkg::HIGH_HEALTH) == 8'h00))
      else $error("a good latch recovered without reset");

   chk_high_hold: assert property (seen_reset |->
      (monitor_before & ~monitor_latch) == 8'h00)
      else $error("a fault latch dropped without reset");

   // latches may still move from live faults during a write, so read data is what a write must not touch
   chk_write_inert: assert property (ce && reg_wr && !reg_rd |=>
      reg_wr_done && $stable(reg_rdata))
      else $error("write changed read data or went unanswered");

   chk_read_data: assert property (ce && reg_rd && reg_addr == supply_status_pkg::ADDR_HEALTH
      |=> reg_rd_valid && reg_rdata == $past(flags.health))
      else $error("health read returned wrong data");

   chk_unmapped: assert property (ce && reg_rd && !addr_mapped(reg_addr) |=>
      reg_addr_error && reg_rdata == supply_status_pkg::READ_UNMAPPED)
      else $error("unmapped read not flagged");

   chk_freeze: assert property (!ce |=> $stable(flags.health) && $stable(fault_latch))
      else $error("state moved while clock enable low");

   chk_fault_hold: assert property (seen_reset |->
      (fault_before & supply_status_pkg::HIGH_FAULT_PIN & ~fault_latch) == 8'h00
      && (fault_latch & ~fault_before & ~supply_status_pkg::HIGH_FAULT_PIN) == 8'h00)
      else $error("a pin or status latch changed without reset");

   chk_pulse_copy: assert property (ce && !flags.fault_pin[supply_status_pkg::F_PULSE] |=>
      !fault_latch[supply_status_pkg::F_PULSE])
      else $error("pulse latch missed the live fault");

   chk_timeout_latch: assert property (ce && ocp_timeout ##1 ce |=>
      monitor_latch[supply_status_pkg::M_OCP_TO])
      else $error("overcurrent timeout latch not set");

   chk_uv_latch: assert property (ce && uv_fault ##1 ce |=>
      monitor_latch[supply_status_pkg::M_UV])
      else $error("undervoltage fault latch not set");

   chk_wr_done: assert property (ce && reg_wr |=> reg_wr_done)
      else $error("write not acknowledged");

   chk_rd_pulse: assert property (ce && !reg_rd |=> !reg_rd_valid)
      else $error("read valid without a read");

   chk_mon_read: assert property (ce && reg_rd && reg_addr == supply_status_pkg::ADDR_MON_LATCH
      |=> reg_rdata == $past(monitor_latch))
      else $error("monitor latch read returned wrong data");

   chk_latch_freeze: assert property (!ce |=> $stable(health_latch) && $stable(monitor_latch)
      && $stable(reg_rdata))
      else $error("latch or read data moved while clock enable low");
endmodule

// [host_model.sv]
// host model: single register reads and writes over the parallel register port
`timescale 1ns/1ps
module host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rd_valid,
   input  wire logic       reg_wr_done,
   input  wire logic       reg_addr_error,
   output logic      [7:0] reg_addr,
   output logic            reg_rd,
   output logic            reg_wr
);
   initial begin
      reg_addr = 8'h00;
      reg_rd   = 1'b0;
      reg_wr   = 1'b0;
   end
   // one strobe cycle; the answer is registered, so look from the next falling edge on
   task automatic access(input logic wr, input logic [7:0] addr, output logic [7:0] data,
                         output logic err, output logic ok);
      int n;
      ok = 1'b0;
      err = 1'b0;
      data = 8'h00;
      @(negedge ref_clk);
      reg_addr <= addr;
      reg_rd <= ~wr;
      reg_wr <= wr;
      @(negedge ref_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      // a released address never keeps its last value
      reg_addr <= ~addr;
      for (n = 0; n < 4 && !ok; n++) begin
         if (reg_rd_valid === 1'b1 || reg_wr_done === 1'b1 || reg_addr_error === 1'b1) begin
            ok = 1'b1;
            data = reg_rdata;
            err = reg_addr_error;
         end else begin
            @(negedge ref_clk);
         end
      end
   endtask
endmodule

// [tb_supply_status_flag_bank.sv]
// self-checking bench for the supply status flag bank
`timescale 1ns/1ps
module tb_supply_status_flag_bank;
   logic        ref_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        ce      = 1'b1;
   logic [24:0] fv      = '0;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_rdata;
   logic        reg_rd;
   logic        reg_wr;
   logic        reg_rd_valid;
   logic        reg_wr_done;
   logic        reg_addr_error;
   int          bad_count = 0;
   int          compares  = 0;
   // one fault per case: expected live 0x01, live 0x02 and monitor latch 0x2a
   logic [7:0]  eh [25] = '{0: 8'hEF, 1: 8'hEC, 2: 8'hEA, 3: 8'hE6, 4: 8'hEE, 5: 8'h9E, 6: 8'hBE,
                           7: 8'hBE, 8: 8'h7E, 9: 8'hBE, default: 8'hFE};
   logic [7:0]  ef [25] = '{9: 8'hF8, 10: 8'hFB, 11: 8'hFB, 12: 8'hFB, 13: 8'hFE, 15: 8'hF2,
                           16: 8'hEA, 17: 8'hDA, 18: 8'hBA, 19: 8'h7A, default: 8'hFA};
   logic [7:0]  em [25] = '{10: 8'h80, 11: 8'h40, 14: 8'h20, 20: 8'h10, 21: 8'h08, 22: 8'h04,
                           23: 8'h02, 24: 8'h01, default: 8'h00};

   always #4 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // design and host
   // ------------------------------------------------------------
   supply_status_flag_bank u_dut (
      .ref_clk(ref_clk), .rstn(rstn), .ce(ce),
      .supply_overvoltage_flag(fv[0]), .ext_ref_overload(fv[1]), .int_ref_lost(fv[2]),
      .ground_open(fv[3]), .supply_uvlo(fv[4]), .reverse_voltage_excess(fv[5]),
      .enable_good(~fv[6]), .load_voltage_good(~fv[7]), .share_out_of_limit(fv[8]),
      .line_pulse_detect(~fv[9]), .ov_fault(fv[10]), .uv_fault(fv[11]), .ocp_event(fv[12]),
      .overcurrent_sensed(fv[13]), .ocp_timer_running(fv[13]), .ocp_timeout(fv[14]),
      .dc_good_pin_state(~fv[15]), .power_on_link_pin(~fv[16]), .enable_pin(~fv[17]),
      .power_on_pin(~fv[18]), .line_sense_pin(~fv[19]), .monitor_input(fv[24:20]),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .reg_wr_done(reg_wr_done), .reg_addr_error(reg_addr_error));

   host_model u_host (
      .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .reg_wr_done(reg_wr_done), .reg_addr_error(reg_addr_error),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic access(input logic wr, input logic [7:0] addr, output logic [7:0] data,
                         output logic err);
      logic ok;
      u_host.access(wr, addr, data, err, ok);
      check("answer", {7'h00, ok}, 8'h01);
   endtask

   task automatic rd_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic       e;
      access(1'b0, addr, d, e);
      check(what, d, exp);
   endtask

   task automatic apply_reset;
      @(negedge ref_clk);
      rstn = 1'b0;
      fv = '0;
      repeat (12) @(negedge ref_clk);
      rstn = 1'b1;
   endtask

   task automatic end_sim;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset;
      rd_check("reset 01", 8'h01, 8'hFE);
      rd_check("reset 02", 8'h02, 8'hFA);
      rd_check("reset 2a", 8'h2A, 8'h00);
      rd_check("reset 2b", 8'h2B, 8'hFE);
      rd_check("reset 2c", 8'h2C, 8'hFA);
      $display("test_reset done");
   endtask

   // each fault alone: live bytes while present, then latches after it has gone
   task automatic test_flags;
      for (int i = 0; i < 25; i++) begin
         apply_reset();
         fv <= 25'h000_0001 << i;
         repeat (3) @(negedge ref_clk);
         rd_check($sformatf("live 01 case %0d", i), 8'h01, eh[i]);
         rd_check($sformatf("live 02 case %0d", i), 8'h02, ef[i]);
         fv <= '0;
         repeat (3) @(negedge ref_clk);
         rd_check($sformatf("after 01 case %0d", i), 8'h01, 8'hFE);
         rd_check($sformatf("after 02 case %0d", i), 8'h02, 8'hFA | {7'h00, ef[i][0]});
         rd_check($sformatf("latch 2a case %0d", i), 8'h2A, em[i]);
         rd_check($sformatf("latch 2b case %0d", i), 8'h2B, eh[i]);
         rd_check($sformatf("latch 2c case %0d", i), 8'h2C, ef[i]);
      end
      $display("test_flags done");
   endtask

   // writes are answered but change nothing; an unmapped address reads zero with an error
   task automatic test_access;
      logic [7:0] addrs [5] = '{8'h01, 8'h02, 8'h2A, 8'h2B, 8'h2C};
      logic [7:0] vals  [5] = '{8'hFE, 8'hFA, 8'h01, 8'hFE, 8'hFA};
      logic [7:0] d;
      logic       e;
      for (int k = 0; k < 5; k++) begin
         access(1'b1, addrs[k], d, e);
         check("write error", {7'h00, e}, 8'h00);
         rd_check("after write", addrs[k], vals[k]);
      end
      access(1'b0, 8'h10, d, e);
      check("unmapped data", d, 8'h00);
      check("unmapped read error", {7'h00, e}, 8'h01);
      access(1'b1, 8'h10, d, e);
      check("unmapped write error", {7'h00, e}, 8'h01);
      $display("test_access done");
   endtask

   // a fault that comes and goes while clock enable is low is never seen
   task automatic test_freeze;
      apply_reset();
      ce <= 1'b0;
      fv <= 25'h000_0008;
      repeat (3) @(negedge ref_clk);
      fv <= '0;
      @(negedge ref_clk);
      ce <= 1'b1;
      repeat (3) @(negedge ref_clk);
      rd_check("frozen 01", 8'h01, 8'hFE);
      rd_check("frozen 2b", 8'h2B, 8'hFE);
      $display("test_freeze done");
   endtask

   initial begin
      repeat (12) @(negedge ref_clk);
      rstn = 1'b1;
      test_reset();
      test_flags();
      test_access();
      test_freeze();
      end_sim();
   end

   initial begin
      repeat (4000) @(posedge ref_clk);
      bad_count++;
      end_sim();
   end
endmodule
